// ===== inc/tphar_defs.svh
// Offsets, field positions, reset values and timing counts of the readout block
`ifndef TPHAR_DEFS_SVH
`define TPHAR_DEFS_SVH

// ==========================================
// Register offsets
`define TPHAR_MEAS_CTRL_ADDR   8'h85
`define TPHAR_RES_LOW_ADDR     8'hAA
`define TPHAR_RES_HIGH_ADDR    8'hAB

// ==========================================
// Measurement control fields
`define TPHAR_SEL_LSB          0
`define TPHAR_SEL_W            4
`define TPHAR_START_BIT        4
`define TPHAR_GAIN_LSB         6
`define TPHAR_GAIN_W           2
`define TPHAR_MEAS_CTRL_RST    8'h00
`define TPHAR_MEAS_CTRL_MASK   8'hDF

// ==========================================
// Conversion result layout
`define TPHAR_RES_W            14
`define TPHAR_RES_SIGN_CODE    14'h1FFF
`define TPHAR_RES_RST          14'h0000

// ==========================================
// Timing
`define TPHAR_CLK_KHZ          25000
`define TPHAR_CONV_US          100
`define TPHAR_CONV_CYCLES      ((`TPHAR_CONV_US * `TPHAR_CLK_KHZ) / 1000)
`define TPHAR_WDOG_MS          1000
`define TPHAR_WDOG_CYCLES      (`TPHAR_WDOG_MS * `TPHAR_CLK_KHZ)

`endif

// ===== inc/tphar_pkg.sv
// Types shared by the readout block
`default_nettype none
package tphar_pkg;
	// ==========================================
	// Serial slave states, one-hot
	typedef enum logic [8:0] {
		I2C_IDLE = 9'h001,
		I2C_ADDR = 9'h002,
		I2C_AACK = 9'h004,
		I2C_PTR  = 9'h008,
		I2C_PACK = 9'h010,
		I2C_WR   = 9'h020,
		I2C_WACK = 9'h040,
		I2C_RD   = 9'h080,
		I2C_RACK = 9'h100
	} tphar_i2c_t;
endpackage
`default_nettype wire

// ===== verilog/tphar_top.sv
// Thermistor protection flags and host-driven conversion readout behind a serial slave
`include "tphar_defs.svh"
`default_nettype none

// How it works
// - Thermistor below hot limit sets hot flag
// - Auto mode: hot flag turns matching FET off
// - Balance hot flag blocks all balancing outputs
// - Host FET control: flags only, no FET action
// - FET mode excludes sensor two from balance
// - Thermistor above cold limit sets cold flag
// - Auto mode: cold flag turns matching FET off
// - Balance cold flag blocks all balancing outputs
// - Flags clear once reading back in range
// - Scan control halts scan, starts watchdog
// - Start bit under scan control begins conversion
// - Completion loads 14-bit result register pair
// - No acknowledge until conversion is complete
// - Scan due while held runs after release
// - Current gain output follows gain field
// - Result is signed 14-bit code
// - Thresholds use 12-bit cell code encoding
module tphar_top #(
	parameter logic [6:0]  DEV_ADDR    = 7'h28,
	parameter int unsigned TEMP_W      = 12,
	parameter int unsigned CELLS       = 8,
	parameter int unsigned WDOG_CYCLES = `TPHAR_WDOG_CYCLES
) (
	input  wire logic                     mclk,
	input  wire logic                     rst_b,
	input  wire logic                     ce,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_b,
	input  wire logic                     host_fet_control,
	input  wire logic                     host_scan_control,
	input  wire logic                     sensor_two_fet_mode,
	input  wire logic [TEMP_W-1:0]        ext_thermistor_one,
	input  wire logic [TEMP_W-1:0]        ext_thermistor_two,
	input  wire logic [TEMP_W-1:0]        charge_hot_limit,
	input  wire logic [TEMP_W-1:0]        discharge_hot_limit,
	input  wire logic [TEMP_W-1:0]        balance_hot_limit,
	input  wire logic [TEMP_W-1:0]        charge_cold_limit,
	input  wire logic [TEMP_W-1:0]        discharge_cold_limit,
	input  wire logic [TEMP_W-1:0]        balance_cold_limit,
	input  wire logic [CELLS-1:0]         balance_request,
	input  wire logic                     scan_due,
	input  wire logic [`TPHAR_RES_W-1:0]  adc_sample,
	output logic                          charge_hot_flag,
	output logic                          discharge_hot_flag,
	output logic                          balance_hot_flag,
	output logic                          charge_cold_flag,
	output logic                          discharge_cold_flag,
	output logic                          balance_cold_flag,
	output logic                          charge_fet_off,
	output logic                          discharge_fet_off,
	output logic [CELLS-1:0]              balance_out,
	output logic                          scan_run,
	output logic                          device_in_control,
	output logic                          adc_start,
	output logic                          adc_busy,
	output logic [`TPHAR_SEL_W-1:0]       adc_select,
	output logic [`TPHAR_GAIN_W-1:0]      current_gain_field,
	output logic                          result_negative
);
	import tphar_pkg::*;

	// ==========================================
	// Helper functions

	// Either sensor reads below a limit; sensor two only when enabled
	function automatic logic any_below(input logic [TEMP_W-1:0] t1,
		input logic [TEMP_W-1:0] t2, input logic use2, input logic [TEMP_W-1:0] lim);
		any_below = (t1 < lim) || (use2 && (t2 < lim));
	endfunction

	// Either sensor reads above a limit; sensor two only when enabled
	function automatic logic any_above(input logic [TEMP_W-1:0] t1,
		input logic [TEMP_W-1:0] t2, input logic use2, input logic [TEMP_W-1:0] lim);
		any_above = (t1 > lim) || (use2 && (t2 > lim));
	endfunction

	// ==========================================
	// Declarations
	logic [2:0]                scl_sync;     // Clock pin synchroniser
	logic [2:0]                sda_sync;     // Data pin synchroniser
	logic                      scl_f;        // Settled clock level
	logic                      sda_f;        // Settled data level
	logic                      scl_rise;     // Clock rising this cycle
	logic                      scl_fall;     // Clock falling this cycle
	logic                      i2c_start;    // Start condition seen
	logic                      i2c_stop;     // Stop condition seen
	tphar_i2c_t                state;        // Slave state
	logic [3:0]                bit_cnt;      // Bits taken in current byte
	logic [7:0]                shift;        // Incoming bits
	logic [7:0]                tx_byte;      // Byte being sent
	logic [7:0]                ptr;          // Register pointer
	logic                      rw;           // Read transfer
	logic                      byte_ack;     // Slave acked a byte or master acked a read byte
	logic                      wr_strobe;    // Register write this cycle
	logic [7:0]                meas_ctrl;    // Measurement control register
	logic [`TPHAR_RES_W-1:0]   result;       // Conversion result pair
	logic [15:0]               conv_cnt;     // Conversion timer
	logic [31:0]               wd_cnt;       // Watchdog timer
	logic                      wd_expired;   // Watchdog ran out
	logic                      scan_pending; // Scan waiting for release
	logic                      host_hold;    // Host holds the scan
	logic                      auto_fet;     // Device may act on FETs
	logic                      use_two_bal;  // Sensor two counts for balance
	logic                      bal_block;    // Balancing forbidden

	localparam logic [15:0] CONV_LAST = 16'(`TPHAR_CONV_CYCLES - 1);
	localparam logic [31:0] WDOG_LAST = 32'(WDOG_CYCLES - 1);

	// Host owns the pack while it holds the scan and the watchdog lives
	assign host_hold = host_scan_control && !wd_expired;
	assign auto_fet  = !host_fet_control && !host_hold;
	assign use_two_bal = !sensor_two_fet_mode;
	assign bal_block = balance_hot_flag || balance_cold_flag;

	// ==========================================
	// Pin synchronisers and edge detection

	// Three stages; a level counts once the last two agree
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else if (ce) begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	// Settled levels from agreeing later stages
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end else if (ce) begin
			if (scl_sync[1] == scl_sync[2]) begin
				scl_f <= scl_sync[2];
			end
			if (sda_sync[1] == sda_sync[2]) begin
				sda_f <= sda_sync[2];
			end
		end
	end

	// Changes of the settled levels
	assign scl_rise  = (scl_sync[1] == scl_sync[2]) && scl_sync[2] && !scl_f;
	assign scl_fall  = (scl_sync[1] == scl_sync[2]) && !scl_sync[2] && scl_f;
	assign i2c_start = scl_f && (sda_sync[1] == sda_sync[2]) && !sda_sync[2] && sda_f;
	assign i2c_stop  = scl_f && (sda_sync[1] == sda_sync[2]) && sda_sync[2] && !sda_f;

	// ==========================================
	// Serial slave

	// Byte framing, acknowledge and data drive
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= I2C_IDLE;
			bit_cnt  <= 4'h0;
			shift    <= 8'h00;
			tx_byte  <= 8'h00;
			ptr      <= 8'h00;
			rw       <= 1'b0;
			sda_oe_b <= 1'b1;
			byte_ack <= 1'b0;
			wr_strobe <= 1'b0;
		end else if (ce) begin
			byte_ack  <= 1'b0;
			wr_strobe <= 1'b0;
			if (i2c_start) begin
				// Start or repeated start opens an address byte
				state    <= I2C_ADDR;
				bit_cnt  <= 4'h0;
				sda_oe_b <= 1'b1;
			end else if (i2c_stop) begin
				state    <= I2C_IDLE;
				sda_oe_b <= 1'b1;
			end else if (scl_rise) begin
				// Sample data on the rising clock
				shift   <= {shift[6:0], sda_f};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_fall) begin
				case (state)
					I2C_ADDR: begin
						// Address byte done: answer only when idle
						if (bit_cnt == 4'h8) begin
							if (shift[7:1] == DEV_ADDR && !adc_busy) begin
								sda_oe_b <= 1'b0;
								rw       <= shift[0];
								byte_ack <= 1'b1;
								state    <= I2C_AACK;
							end else begin
								state <= I2C_IDLE;
							end
						end
					end
					I2C_AACK: begin
						// After address ack: send or take a pointer
						bit_cnt <= 4'h0;
						if (rw) begin
							tx_byte  <= read_byte(ptr);
							sda_oe_b <= (read_byte(ptr) > 8'h7F);
							state    <= I2C_RD;
						end else begin
							sda_oe_b <= 1'b1;
							state    <= I2C_PTR;
						end
					end
					I2C_PTR: begin
						// Pointer byte taken
						if (bit_cnt == 4'h8) begin
							ptr      <= shift;
							sda_oe_b <= 1'b0;
							byte_ack <= 1'b1;
							state    <= I2C_PACK;
						end
					end
					I2C_PACK, I2C_WACK: begin
						// Release after ack; next bytes are data
						sda_oe_b <= 1'b1;
						bit_cnt  <= 4'h0;
						state    <= I2C_WR;
					end
					I2C_WR: begin
						// Data byte taken and written at pointer
						if (bit_cnt == 4'h8) begin
							sda_oe_b  <= 1'b0;
							byte_ack  <= 1'b1;
							wr_strobe <= 1'b1;
							state     <= I2C_WACK;
						end
					end
					I2C_RD: begin
						// Shift out the read byte, then release for master ack
						if (bit_cnt == 4'h8) begin
							sda_oe_b <= 1'b1;
							state    <= I2C_RACK;
						end else begin
							sda_oe_b <= tx_byte[3'(7 - bit_cnt)];
						end
					end
					I2C_RACK: begin
						// Master ack repeats the same register, nack ends
						if (!shift[0]) begin
							bit_cnt  <= 4'h0;
							sda_oe_b <= tx_byte[7];
							byte_ack <= 1'b1;
							state    <= I2C_RD;
						end else begin
							state <= I2C_IDLE;
						end
					end
					default: begin
						sda_oe_b <= 1'b1;
					end
				endcase
			end
		end
	end

	// Open drain: the data output only ever pulls low
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sda_out <= 1'b0;
		end else if (ce) begin
			sda_out <= 1'b0;
		end
	end

	// Register read mux; unmapped offsets read zero
	function automatic logic [7:0] read_byte(input logic [7:0] p);
		case (p)
			`TPHAR_MEAS_CTRL_ADDR: read_byte = meas_ctrl & `TPHAR_MEAS_CTRL_MASK;
			`TPHAR_RES_HIGH_ADDR:  read_byte = {2'b00, result[13:8]};
			`TPHAR_RES_LOW_ADDR:   read_byte = result[7:0];
			default:               read_byte = 8'h00;
		endcase
	endfunction

	// ==========================================
	// Measurement control and conversion

	// Control register; the start bit never stays set
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meas_ctrl <= `TPHAR_MEAS_CTRL_RST;
		end else if (ce) begin
			if (wr_strobe && ptr == `TPHAR_MEAS_CTRL_ADDR) begin
				meas_ctrl <= shift & `TPHAR_MEAS_CTRL_MASK & ~(8'h01 << `TPHAR_START_BIT);
			end
		end
	end

	// Select and gain outputs follow the register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			adc_select         <= '0;
			current_gain_field <= '0;
		end else if (ce) begin
			adc_select         <= meas_ctrl[`TPHAR_SEL_LSB +: `TPHAR_SEL_W];
			current_gain_field <= meas_ctrl[`TPHAR_GAIN_LSB +: `TPHAR_GAIN_W];
		end
	end

	// One conversion per start under host scan control
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			adc_start <= 1'b0;
			adc_busy  <= 1'b0;
			conv_cnt  <= 16'h0000;
			result    <= `TPHAR_RES_RST;
		end else if (ce) begin
			adc_start <= 1'b0;
			if (adc_busy) begin
				if (conv_cnt == CONV_LAST) begin
					// Done: load the 14-bit pair, accept the host again
					adc_busy <= 1'b0;
					result   <= adc_sample;
				end else begin
					conv_cnt <= conv_cnt + 16'h0001;
				end
			end else if (wr_strobe && ptr == `TPHAR_MEAS_CTRL_ADDR
					&& shift[`TPHAR_START_BIT] && host_hold) begin
				adc_start <= 1'b1;
				adc_busy  <= 1'b1;
				conv_cnt  <= 16'h0000;
			end
		end
	end

	// Codes from the sign threshold upward read as negative
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			result_negative <= 1'b0;
		end else if (ce) begin
			result_negative <= (result >= `TPHAR_RES_SIGN_CODE);
		end
	end

	// ==========================================
	// Scan hold and watchdog

	// Watchdog runs while the host holds the scan; traffic restarts it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wd_cnt     <= 32'h00000000;
			wd_expired <= 1'b0;
		end else if (ce) begin
			if (!host_scan_control) begin
				wd_cnt     <= 32'h00000000;
				wd_expired <= 1'b0;
			end else if (byte_ack) begin
				wd_cnt <= 32'h00000000;
			end else if (wd_cnt == WDOG_LAST) begin
				wd_expired <= 1'b1;
			end else begin
				wd_cnt <= wd_cnt + 32'h00000001;
			end
		end
	end

	// A scan falling due while held waits and runs on release
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scan_pending      <= 1'b0;
			scan_run          <= 1'b0;
			device_in_control <= 1'b1;
		end else if (ce) begin
			device_in_control <= !host_hold;
			scan_run          <= 1'b0;
			if (host_hold) begin
				scan_pending <= scan_pending || scan_due;
			end else if (scan_due || scan_pending) begin
				scan_run     <= 1'b1;
				scan_pending <= 1'b0;
			end
		end
	end

	// ==========================================
	// Temperature protection

	// Flags follow the comparisons; they drop once back in range
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			charge_hot_flag     <= 1'b0;
			discharge_hot_flag  <= 1'b0;
			balance_hot_flag    <= 1'b0;
			charge_cold_flag    <= 1'b0;
			discharge_cold_flag <= 1'b0;
			balance_cold_flag   <= 1'b0;
		end else if (ce) begin
			// Lower reading means hotter, 12-bit codes throughout
			charge_hot_flag     <= any_below(ext_thermistor_one, ext_thermistor_two,
				1'b1, charge_hot_limit);
			discharge_hot_flag  <= any_below(ext_thermistor_one, ext_thermistor_two,
				1'b1, discharge_hot_limit);
			balance_hot_flag    <= any_below(ext_thermistor_one, ext_thermistor_two,
				use_two_bal, balance_hot_limit);
			charge_cold_flag    <= any_above(ext_thermistor_one, ext_thermistor_two,
				1'b1, charge_cold_limit);
			discharge_cold_flag <= any_above(ext_thermistor_one, ext_thermistor_two,
				1'b1, discharge_cold_limit);
			balance_cold_flag   <= any_above(ext_thermistor_one, ext_thermistor_two,
				use_two_bal, balance_cold_limit);
		end
	end

	// FET switch-off only in automatic mode
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			charge_fet_off    <= 1'b0;
			discharge_fet_off <= 1'b0;
		end else if (ce) begin
			charge_fet_off    <= auto_fet && (charge_hot_flag || charge_cold_flag);
			discharge_fet_off <= auto_fet
				&& (discharge_hot_flag || discharge_cold_flag);
		end
	end

	// Balancing outputs forced off while either balance flag stands
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			balance_out <= '0;
		end else if (ce) begin
			balance_out <= bal_block ? '0 : balance_request;
		end
	end

endmodule
`default_nettype wire

// ===== bench/tphar_top_asserts.sv
// Port-level checks of the readout block, bound into its top module
`default_nettype none
module tphar_top_asserts #(
	parameter int unsigned TEMP_W = 12,
	parameter int unsigned CELLS  = 8
) (
	input wire logic              mclk,
	input wire logic              rst_b,
	input wire logic              ce,
	input wire logic              host_fet_control,
	input wire logic              host_scan_control,
	input wire logic              sensor_two_fet_mode,
	input wire logic [TEMP_W-1:0] ext_thermistor_one,
	input wire logic [TEMP_W-1:0] ext_thermistor_two,
	input wire logic [TEMP_W-1:0] charge_hot_limit,
	input wire logic [TEMP_W-1:0] balance_hot_limit,
	input wire logic [TEMP_W-1:0] charge_cold_limit,
	input wire logic              charge_hot_flag,
	input wire logic              balance_hot_flag,
	input wire logic              charge_cold_flag,
	input wire logic              balance_cold_flag,
	input wire logic              charge_fet_off,
	input wire logic              discharge_fet_off,
	input wire logic [CELLS-1:0]  balance_out,
	input wire logic              scan_run,
	input wire logic              device_in_control,
	input wire logic              adc_start,
	input wire logic              adc_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Helper compares and busy length counter
	logic        chot_c;	// Charge hot compare
	logic        bhot_c;	// Balance hot compare
	logic        ccold_c;	// Charge cold compare
	logic [11:0] bcnt;	// Cycles spent busy
	assign chot_c = (ext_thermistor_one < charge_hot_limit)
		|| (ext_thermistor_two < charge_hot_limit);
	assign bhot_c = (ext_thermistor_one < balance_hot_limit)
		|| (!sensor_two_fet_mode && (ext_thermistor_two < balance_hot_limit));
	assign ccold_c = (ext_thermistor_one > charge_cold_limit)
		|| (ext_thermistor_two > charge_cold_limit);
	// Count busy cycles, cleared while idle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bcnt <= 12'h000;
		end else if (!adc_busy) begin
			bcnt <= 12'h000;
		end else if (ce) begin
			bcnt <= bcnt + 12'h001;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Assertions
	property p_chg_hot; ce |=> charge_hot_flag == $past(chot_c); endproperty
	a_chg_hot: assert property (p_chg_hot) else $error("charge hot flag wrong");
	property p_bal_hot; ce |=> balance_hot_flag == $past(bhot_c); endproperty
	a_bal_hot: assert property (p_bal_hot) else $error("balance hot flag wrong");
	property p_chg_cold; ce |=> charge_cold_flag == $past(ccold_c); endproperty
	a_chg_cold: assert property (p_chg_cold) else $error("charge cold flag wrong");
	property p_fet_auto;
		ce && !host_fet_control && !host_scan_control && (charge_hot_flag || charge_cold_flag)
		|-> ##[0:1] charge_fet_off;
	endproperty
	a_fet_auto: assert property (p_fet_auto) else $error("charge FET left on");
	property p_fet_host; (ce && host_fet_control) [*2] |-> !charge_fet_off && !discharge_fet_off;
	endproperty
	a_fet_host: assert property (p_fet_host) else $error("FET action under host");
	property p_bal_block;
		ce && (balance_hot_flag || balance_cold_flag) |=> balance_out == '0;
	endproperty
	a_bal_block: assert property (p_bal_block) else $error("balancing not blocked");
	property p_start; adc_start |-> adc_busy ##1 !adc_start; endproperty
	a_start: assert property (p_start) else $error("start pulse wrong");
	property p_hold; $rose(host_scan_control) && ce |-> ##[1:2] !device_in_control; endproperty
	a_hold: assert property (p_hold) else $error("scan hold not taken");
	property p_no_scan; !device_in_control |-> !scan_run; endproperty
	a_no_scan: assert property (p_no_scan) else $error("scan ran while held");
	property p_conv_len; $fell(adc_busy) |-> bcnt == 12'h9C4; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
endmodule
bind tphar_top tphar_top_asserts #(.TEMP_W(TEMP_W), .CELLS(CELLS)) tphar_top_asserts_inst (.*);
`default_nettype wire

// ===== bench/tphar_host_model.sv
// Serial master standing in for the host controller
`default_nettype none
module tphar_host_model #(
	parameter logic [6:0] ADDR = 7'h28
) (
	input  wire logic mclk,
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_wire
);
	timeunit 1ns;
	timeprecision 100ps;
	// Bus idles released, pull-up holds it high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Start or repeated start
	task automatic start;
		sda_drv = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b1;
		tick(4);
	endtask
	// One bit, sampled mid-high
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		tick(4);
		scl = 1'b1;
		tick(4);
		r = sda_wire;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask
	// Byte out, ack back
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = !r;
	endtask
	// Byte in, then nack to end the read
	task automatic get(output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, q[i]);
		end
		bit_x(1'b1, r);
	endtask
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		put({ADDR, 1'b0}, a0);
		put(ptr, a1);
		put(d, a2);
		stop();
		ok = a0 && a1 && a2;
	endtask
	// Pointer, repeated start, one byte read
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] q);
		logic a;
		start();
		put({ADDR, 1'b0}, a);
		put(ptr, a);
		start();
		put({ADDR, 1'b1}, a);
		get(q);
		stop();
	endtask
	// Address probe, acked only once conversion ends
	task automatic poll(output logic ok);
		start();
		put({ADDR, 1'b0}, ok);
		stop();
	endtask
endmodule
`default_nettype wire

// ===== bench/test_temp_protect_host_adc_readout.sv
// Self-checking bench for the readout block
`default_nettype none
module test_temp_protect_host_adc_readout;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, rst_b, ce, scl, sda_drv, sda_out, sda_oe_b;
	logic        host_fet_control, host_scan_control, sensor_two_fet_mode, scan_due;
	logic        adc_busy, scan_run, dic, adc_start, neg, ok;
	logic [11:0] t1, t2, chl, bhl, ccl;
	logic [7:0]  flags, bal, q, breq;
	logic [3:0]  sel;
	logic [1:0]  gain;
	logic [13:0] adc_sample;
	int          num_errors = 0;
	int          n_checks = 0;
	int          scan_cnt = 0;
	int          tries;
	wire logic   sda_wire = sda_drv && (sda_oe_b || sda_out);	// Open drain with pull-up
	tphar_top #(.WDOG_CYCLES(4000)) tphar_top_inst (
		.mclk(mclk), .rst_b(rst_b), .ce(ce), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_b(sda_oe_b), .host_fet_control(host_fet_control),
		.host_scan_control(host_scan_control), .sensor_two_fet_mode(sensor_two_fet_mode),
		.ext_thermistor_one(t1), .ext_thermistor_two(t2),
		.charge_hot_limit(chl), .discharge_hot_limit(12'h0C0), .balance_hot_limit(bhl),
		.charge_cold_limit(ccl), .discharge_cold_limit(12'hD00), .balance_cold_limit(12'hB00),
		.balance_request(breq), .scan_due(scan_due), .adc_sample(adc_sample),
		.charge_hot_flag(flags[7]), .discharge_hot_flag(flags[6]), .balance_hot_flag(flags[5]),
		.charge_cold_flag(flags[4]), .discharge_cold_flag(flags[3]), .balance_cold_flag(flags[2]),
		.charge_fet_off(flags[1]), .discharge_fet_off(flags[0]), .balance_out(bal),
		.scan_run(scan_run), .device_in_control(dic), .adc_start(adc_start), .adc_busy(adc_busy),
		.adc_select(sel), .current_gain_field(gain), .result_negative(neg)
	);
	tphar_host_model host_inst (.mclk(mclk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
	// Clock and scan pulse counter
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) if (scan_run === 1'b1) scan_cnt++;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk_b(input string n, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Set sensors and modes, compare flags, FET and balance outputs
	task automatic temp_case(input logic [11:0] a, input logic [11:0] b, input logic m,
		input logic f, input logic [7:0] e, input logic [7:0] be);
		t1 = a;
		t2 = b;
		sensor_two_fet_mode = m;
		host_fet_control = f;
		tick(4);
		chk_v("flags", e, flags);
		chk_v("balance", be, bal);
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
		host_inst.read_reg(ptr, q);
		chk_v("register", e, q);
	endtask
	// Hang guard
	initial begin
		#1600000;
		num_errors++;
		conclude();
	end
	initial begin
		{ce, rst_b, host_fet_control, host_scan_control, sensor_two_fet_mode} = 5'b10000;
		scan_due = 1'b0;
		t1 = 12'h320;
		t2 = 12'h320;
		adc_sample = 14'h2ABC;
		{chl, bhl, ccl, breq} = {12'h100, 12'h140, 12'hC00, 8'hA5};
		tick(4);
		rst_b = 1'b1;
		tick(4);
		temp_case(12'h320, 12'h320, 1'b0, 1'b0, 8'h00, 8'hA5);
		temp_case(12'h0F0, 12'h320, 1'b0, 1'b0, 8'hA2, 8'h00);
		temp_case(12'h320, 12'h0B0, 1'b0, 1'b0, 8'hE3, 8'h00);
		temp_case(12'h320, 12'h0B0, 1'b1, 1'b0, 8'hC3, 8'hA5);
		temp_case(12'h320, 12'h0B0, 1'b1, 1'b1, 8'hC0, 8'hA5);
		temp_case(12'hC80, 12'h320, 1'b0, 1'b0, 8'h16, 8'h00);
		temp_case(12'h320, 12'hD80, 1'b0, 1'b0, 8'h1F, 8'h00);
		temp_case(12'h320, 12'h320, 1'b0, 1'b0, 8'h00, 8'hA5);
		// Start without scan hold is ignored
		host_inst.write_reg(8'h85, 8'h11, ok);
		tick(4);
		chk_b("busy_unheld", 1'b0, adc_busy);
		host_scan_control = 1'b1;
		tick(4);
		chk_b("in_control", 1'b0, dic);
		scan_due = 1'b1;
		tick(1);
		scan_due = 1'b0;
		host_inst.write_reg(8'h85, 8'hD3, ok);
		chk_b("start_ack", 1'b1, ok);
		tick(3);
		chk_b("busy", 1'b1, adc_busy);
		chk_v("sel_gain", 8'hC3, {gain, 2'b00, sel});
		host_inst.poll(ok);
		chk_b("busy_nack", 1'b0, ok);
		tries = 0;
		while (!ok && tries < 60) begin
			host_inst.poll(ok);
			tries++;
		end
		chk_b("done_ack", 1'b1, ok);
		chk_b("busy_end", 1'b0, adc_busy);
		rd(8'hAB, 8'h2A);
		rd(8'hAA, 8'hBC);
		chk_b("negative", 1'b1, neg);
		host_inst.write_reg(8'hAA, 8'h55, ok);
		rd(8'hAA, 8'hBC);
		rd(8'h85, 8'hC3);
		rd(8'h10, 8'h00);
		// Lowest negative code: the sign threshold itself
		adc_sample = 14'h1FFF;
		host_inst.write_reg(8'h85, 8'h10, ok);
		tick(2600);
		chk_b("negative_edge", 1'b1, neg);
		chk_v("scan_held", 8'h00, 8'(scan_cnt));
		host_scan_control = 1'b0;
		tick(4);
		chk_v("scan_after", 8'h01, 8'(scan_cnt));
		chk_b("in_control_back", 1'b1, dic);
		// Silent host hold runs the watchdog out
		host_scan_control = 1'b1;
		tick(4);
		scan_due = 1'b1;
		tick(1);
		scan_due = 1'b0;
		tick(4100);
		chk_b("wdog_control", 1'b1, dic);
		chk_v("wdog_scan", 8'h02, 8'(scan_cnt));
		host_scan_control = 1'b0;
		tick(4);
		conclude();
	end
endmodule
`default_nettype wire
